// >>> src/sdlpc_params.svh
// Constants of the shared digital I/O and LCD pin control block.
// Assumes inclusion by bare name from the router and top design files of the block.
`ifndef SDLPC_PARAMS_SVH
`define SDLPC_PARAMS_SVH

// Pin counts and pin group boundaries
`define SDLPC_NPIN          59
`define SDLPC_DIR_SEG_PIN   24
`define SDLPC_DATA_SEG_PIN  36
`define SDLPC_DED_PIN       56
`define SDLPC_SEG_OFS       20
`define SDLPC_SEG_FIRST     44
`define SDLPC_NSEGB         16
`define SDLPC_NSRC          13

// Bit positions inside shared and dedicated bytes
`define SDLPC_SEG_DIR_BIT   3
`define SDLPC_SEG_DATA_BIT  0
`define SDLPC_SEG_HI_OFS    4
`define SDLPC_DED_DIR_BIT   7
`define SDLPC_DED_DATA_BIT  4

// Processor port registers
`define SDLPC_A_PORT0       16'h0080
`define SDLPC_A_PORT1       16'h0090
`define SDLPC_A_PORT2       16'h00A0
`define SDLPC_A_PORT3       16'h00B0
`define SDLPC_A_PORT4       16'h00C0
`define SDLPC_A_DIR0        16'h00A2
`define SDLPC_A_DIR1        16'h0091
`define SDLPC_A_DIR2        16'h00A1

// I/O RAM registers
`define SDLPC_A_RSEL_LO     16'h2009
`define SDLPC_A_RSEL_HI     16'h200F
`define SDLPC_A_STAT        16'h2010
`define SDLPC_A_MASK        16'h2011
`define SDLPC_A_CTRL        16'h2012
`define SDLPC_A_MAP_LO      16'h2020
`define SDLPC_A_MAP_HI      16'h2023
`define SDLPC_A_SEG_LO      16'h203C
`define SDLPC_A_SEG_HI      16'h204B
`define SDLPC_A_DED_LO      16'h2050
`define SDLPC_A_DED_HI      16'h2052

// Control register fields
`define SDLPC_C_OPT_IO      0
`define SDLPC_C_EE_SEL      1
`define SDLPC_C_PW_EN       2
`define SDLPC_C_PV_EN       3
`define SDLPC_C_PX_EN       4
`define SDLPC_C_PY_EN       5

// Resource selector codes
`define SDLPC_R_T0          3'h2
`define SDLPC_R_T1          3'h3
`define SDLPC_R_HI_RISE     3'h4
`define SDLPC_R_LO_RISE     3'h5
`define SDLPC_R_HI_FALL     3'h6
`define SDLPC_R_LO_FALL     3'h7

// Reset values
`define SDLPC_RST_BYTE      8'h00
`define SDLPC_RST_CTRL      8'h00

`endif

// >>> src/sdlpc_pkg.sv
// Types shared by the pin control block.
// Assumes sdlpc_params.svh is available on the include path.
package sdlpc_pkg;
   typedef logic [15:0] sdlpc_addr_t;
   typedef logic [7:0]  sdlpc_byte_t;
   typedef logic [2:0]  sdlpc_sel_t;
endpackage

// >>> src/sdlpc_route.sv
// One resource router: turns a source level and its selector into resource requests.
// Assumes the caller registers the previous level and ORs all routers together.
`timescale 1ns/1ps
`include "sdlpc_params.svh"

module sdlpc_route (
   input  wire sdlpc_pkg::sdlpc_sel_t sel,
   input  wire logic                  lvl,
   input  wire logic                  prev,
   output logic                       t0_clk,
   output logic                       t1_clk,
   output logic                       hi_evt,
   output logic                       lo_evt
);
   import sdlpc_pkg::*;

   logic rise;
   logic fall;

   // Edges of the actual pin level, so own driven pulses count too
   assign rise = lvl & ~prev;
   assign fall = ~lvl & prev;

   // Decode of the selector code; codes 0 and 1 route nothing
   always_comb begin
      t0_clk = 1'b0;
      t1_clk = 1'b0;
      hi_evt = 1'b0;
      lo_evt = 1'b0;
      case (sel)
         `SDLPC_R_T0:      t0_clk = lvl;
         `SDLPC_R_T1:      t1_clk = lvl;
         `SDLPC_R_HI_RISE: hi_evt = rise;
         `SDLPC_R_LO_RISE: lo_evt = rise;
         `SDLPC_R_HI_FALL: hi_evt = fall;
         `SDLPC_R_LO_FALL: lo_evt = fall;
         default:          t0_clk = 1'b0;
      endcase
   end
endmodule

// >>> src/sdlpc_top.sv
// Shared digital I/O and LCD segment pin control, with resource routing.
// Assumes a single-cycle register port and pad logic that resolves out/oe.
`timescale 1ns/1ps
`include "sdlpc_params.svh"

module sdlpc_top (
   input  wire logic                      mclk,
   input  wire logic                      rst,
   input  wire sdlpc_pkg::sdlpc_addr_t    addr,
   input  wire sdlpc_pkg::sdlpc_byte_t    wdata,
   input  wire logic                      wr_stb,
   input  wire logic                      rd_stb,
   output sdlpc_pkg::sdlpc_byte_t         rdata,
   input  wire logic [`SDLPC_NPIN-1:0]    general_pin_in,
   output logic [`SDLPC_NPIN-1:0]         general_pin_out,
   output logic [`SDLPC_NPIN-1:0]         general_pin_oe,
   output logic [`SDLPC_NPIN-1:0]         pin_lcd_select,
   input  wire logic                      push_button_input,
   input  wire logic                      uart_tx_data,
   output logic                           uart_rx_data,
   input  wire logic                      real_energy_pulse,
   input  wire logic                      reactive_energy_pulse,
   input  wire logic                      extra_pulse_x,
   input  wire logic                      extra_pulse_y,
   input  wire logic                      ee_clk,
   input  wire logic                      ee_data_out,
   input  wire logic                      ee_data_oe,
   output logic                           ee_data_in,
   output logic                           counter_zero_clock,
   output logic                           counter_one_clock,
   output logic                           high_priority_pin_irq,
   output logic                           low_priority_pin_irq,
   output logic                           irq
);
   import sdlpc_pkg::*;

   localparam int NP = `SDLPC_NPIN;
   localparam int NS = `SDLPC_NSRC;

   // Register storage
   logic [39:0]      port_data_ff;
   logic [23:0]      dir_ff;
   sdlpc_byte_t      seg_ff [`SDLPC_NSEGB];
   sdlpc_byte_t      ded_ff [3];
   logic [31:0]      map_ff;
   sdlpc_byte_t      rsel_ff [7];
   sdlpc_byte_t      ctrl_ff;
   logic [1:0]       stat_ff;
   logic [1:0]       mask_ff;
   sdlpc_byte_t      rdata_ff;

   // Pin and routing state
   logic [NP-1:0]    pin_out_ff;
   logic [NP-1:0]    pin_oe_ff;
   logic [NP-1:0]    lcd_ff;
   logic [NS-1:0]    src_prev_ff;
   logic             t0_ff;
   logic             t1_ff;
   logic             hi_ff;
   logic             lo_ff;
   logic             irq_ff;
   logic             rx_ff;
   logic             ee_in_ff;

   // Combinational values
   logic [NP-1:0]    nxt_pin_out;
   logic [NP-1:0]    nxt_pin_oe;
   logic [NP-1:0]    nxt_lcd;
   logic [NP-1:0]    pin_dir;
   sdlpc_byte_t      seg_rd [`SDLPC_NSEGB];
   sdlpc_byte_t      ded_rd [3];
   sdlpc_byte_t      nxt_rdata;
   logic [NS-1:0]    src_lvl;
   logic [NS-1:0]    r_t0;
   logic [NS-1:0]    r_t1;
   logic [NS-1:0]    r_hi;
   logic [NS-1:0]    r_lo;
   logic [1:0]       nxt_stat;
   logic [1:0]       stat_clr;
   logic             seg_hit;
   logic [3:0]       seg_idx;
   logic             map_hit;
   logic [1:0]       map_idx;
   logic             rsel_hit;
   logic [2:0]       rsel_idx;
   logic             ded_hit;
   logic [1:0]       ded_idx;

   // Byte and bit position of a segment field that belongs to a shared pin
   function automatic int seg_byte(input int pin);
      return ((pin + `SDLPC_SEG_OFS) / 2) - (`SDLPC_SEG_FIRST / 2);
   endfunction

   function automatic int seg_pos(input int pin, input int fld);
      return (((pin + `SDLPC_SEG_OFS) % 2) * `SDLPC_SEG_HI_OFS) + fld;
   endfunction

   // Address range decode for the register groups
   always_comb begin
      seg_hit  = (addr >= `SDLPC_A_SEG_LO) && (addr <= `SDLPC_A_SEG_HI);
      map_hit  = (addr >= `SDLPC_A_MAP_LO) && (addr <= `SDLPC_A_MAP_HI);
      rsel_hit = (addr >= `SDLPC_A_RSEL_LO) && (addr <= `SDLPC_A_RSEL_HI);
      ded_hit  = (addr >= `SDLPC_A_DED_LO) && (addr <= `SDLPC_A_DED_HI);
      seg_idx  = 4'(addr - `SDLPC_A_SEG_LO);
      map_idx  = 2'(addr - `SDLPC_A_MAP_LO);
      rsel_idx = 3'(addr - `SDLPC_A_RSEL_LO);
      ded_idx  = 2'(addr - `SDLPC_A_DED_LO);
   end

   // Port data and direction registers for the low pins
   always_ff @(posedge mclk) begin
      if (rst) begin
         port_data_ff <= '0;
         dir_ff       <= '0;
      end else if (wr_stb) begin
         case (addr)
            `SDLPC_A_PORT0: port_data_ff[7:0]   <= wdata;
            `SDLPC_A_PORT1: port_data_ff[15:8]  <= wdata;
            `SDLPC_A_PORT2: port_data_ff[23:16] <= wdata;
            `SDLPC_A_PORT3: port_data_ff[31:24] <= wdata;
            `SDLPC_A_PORT4: port_data_ff[39:32] <= wdata;
            `SDLPC_A_DIR0:  dir_ff[7:0]         <= wdata;
            `SDLPC_A_DIR1:  dir_ff[15:8]        <= wdata;
            `SDLPC_A_DIR2:  dir_ff[23:16]       <= wdata;
            default:        dir_ff              <= dir_ff;
         endcase
      end
   end

   // Shared segment bytes are written whole; firmware keeps the other half intact
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int b = 0; b < `SDLPC_NSEGB; b++) begin
            seg_ff[b] <= `SDLPC_RST_BYTE;
         end
      end else if (wr_stb && seg_hit) begin
         seg_ff[seg_idx] <= wdata;
      end
   end

   // Dedicated pin bytes and pin function map
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int b = 0; b < 3; b++) begin
            ded_ff[b] <= `SDLPC_RST_BYTE;
         end
         map_ff <= '0;
      end else if (wr_stb) begin
         if (ded_hit && (ded_idx != 2'h3)) begin
            ded_ff[ded_idx] <= wdata;
         end
         if (map_hit) begin
            map_ff[8*map_idx +: 8] <= wdata;
         end
      end
   end

   // Resource selectors, two 3-bit fields per byte
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int b = 0; b < 7; b++) begin
            rsel_ff[b] <= `SDLPC_RST_BYTE;
         end
      end else if (wr_stb && rsel_hit) begin
         rsel_ff[rsel_idx] <= wdata & 8'h77;
      end
   end

   // Control register and interrupt mask
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_ff <= `SDLPC_RST_CTRL;
         mask_ff <= '0;
      end else if (wr_stb) begin
         if (addr == `SDLPC_A_CTRL) begin
            ctrl_ff <= wdata & 8'h3F;
         end
         if (addr == `SDLPC_A_MASK) begin
            mask_ff <= wdata[1:0];
         end
      end
   end

   // Pin resolution: direction, data, function and alternate uses
   always_comb begin
      nxt_pin_out = '0;
      nxt_pin_oe  = '0;
      nxt_lcd     = '0;
      pin_dir     = '0;
      for (int b = 0; b < `SDLPC_NSEGB; b++) begin
         seg_rd[b] = seg_ff[b];
      end
      for (int b = 0; b < 3; b++) begin
         ded_rd[b] = ded_ff[b];
      end
      for (int i = 0; i < NP; i++) begin
         if (i < `SDLPC_DIR_SEG_PIN) begin
            pin_dir[i] = dir_ff[i];
         end else if (i < `SDLPC_DED_PIN) begin
            pin_dir[i] = seg_ff[seg_byte(i)][seg_pos(i, `SDLPC_SEG_DIR_BIT)];
         end else begin
            pin_dir[i] = ded_ff[i-`SDLPC_DED_PIN][`SDLPC_DED_DIR_BIT];
         end
         if ((i >= `SDLPC_DIR_SEG_PIN) && (i < `SDLPC_DED_PIN)) begin
            nxt_lcd[i] = map_ff[i-`SDLPC_DIR_SEG_PIN];
         end
         if (i < `SDLPC_DATA_SEG_PIN) begin
            nxt_pin_out[i] = port_data_ff[i];
         end else if (i < `SDLPC_DED_PIN) begin
            nxt_pin_out[i] = seg_ff[seg_byte(i)][seg_pos(i, `SDLPC_SEG_DATA_BIT)];
            if (!nxt_lcd[i] && !pin_dir[i]) begin
               seg_rd[seg_byte(i)][seg_pos(i, `SDLPC_SEG_DATA_BIT)] = general_pin_in[i];
            end
         end else begin
            nxt_pin_out[i] = ded_ff[i-`SDLPC_DED_PIN][`SDLPC_DED_DATA_BIT];
            if (!pin_dir[i]) begin
               ded_rd[i-`SDLPC_DED_PIN][`SDLPC_DED_DATA_BIT] = general_pin_in[i];
            end
         end
         nxt_pin_oe[i] = !nxt_lcd[i] && pin_dir[i];
      end
      // Optical port owns pins 1 and 2 unless they are released as I/O
      if (!ctrl_ff[`SDLPC_C_OPT_IO]) begin
         nxt_pin_out[1] = uart_tx_data;
         nxt_pin_oe[1]  = 1'b1;
         nxt_pin_oe[2]  = 1'b0;
      end
      // EEPROM engine takes the clock and data lines
      if (ctrl_ff[`SDLPC_C_EE_SEL]) begin
         nxt_pin_out[4] = ee_clk;
         nxt_pin_oe[4]  = 1'b1;
         nxt_pin_out[5] = ee_data_out;
         nxt_pin_oe[5]  = ee_data_oe;
      end
      // Engine pulses replace port data only on pins already set as outputs
      if (ctrl_ff[`SDLPC_C_PW_EN] && pin_dir[6]) begin
         nxt_pin_out[6] = real_energy_pulse;
      end
      if (ctrl_ff[`SDLPC_C_PV_EN] && pin_dir[7]) begin
         nxt_pin_out[7] = reactive_energy_pulse;
      end
      if (ctrl_ff[`SDLPC_C_PX_EN] && pin_dir[8]) begin
         nxt_pin_out[8] = extra_pulse_x;
      end
      if (ctrl_ff[`SDLPC_C_PY_EN] && pin_dir[9]) begin
         nxt_pin_out[9] = extra_pulse_y;
      end
   end

   // Pin drive registers; the push button has no driver at all
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_out_ff <= '0;
         pin_oe_ff  <= '0;
         lcd_ff     <= '0;
         rx_ff      <= 1'b0;
         ee_in_ff   <= 1'b0;
      end else begin
         pin_out_ff <= nxt_pin_out;
         pin_oe_ff  <= nxt_pin_oe;
         lcd_ff     <= nxt_lcd;
         rx_ff      <= general_pin_in[2];
         ee_in_ff   <= general_pin_in[5];
      end
   end

   // Sources: button on selector 0, pins 0..10 on 1..11, receive pin on 12
   always_comb begin
      src_lvl[0] = push_button_input;
      for (int k = 1; k < NS - 1; k++) begin
         src_lvl[k] = general_pin_in[k-1];
      end
      src_lvl[NS-1] = general_pin_in[2];
   end

   genvar g;
   generate
      for (g = 0; g < NS; g++) begin : g_route
         sdlpc_route u_route (
            .sel    ((g % 2 == 1) ? rsel_ff[g/2][6:4] : rsel_ff[g/2][2:0]),
            .lvl    (src_lvl[g]),
            .prev   (src_prev_ff[g]),
            .t0_clk (r_t0[g]),
            .t1_clk (r_t1[g]),
            .hi_evt (r_hi[g]),
            .lo_evt (r_lo[g])
         );
      end
   endgenerate

   // Combined resources; OR of all sources sharing one resource
   always_ff @(posedge mclk) begin
      if (rst) begin
         src_prev_ff <= '0;
         t0_ff       <= 1'b0;
         t1_ff       <= 1'b0;
         hi_ff       <= 1'b0;
         lo_ff       <= 1'b0;
      end else begin
         src_prev_ff <= src_lvl;
         t0_ff       <= |r_t0;
         t1_ff       <= |r_t1;
         hi_ff       <= |r_hi;
         lo_ff       <= |r_lo;
      end
   end

   // Sticky status, write one to clear; a new event beats the clear
   always_comb begin
      stat_clr = (wr_stb && (addr == `SDLPC_A_STAT)) ? wdata[1:0] : 2'h0;
      nxt_stat = (stat_ff & ~stat_clr) | {|r_lo, |r_hi};
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         stat_ff <= '0;
         irq_ff  <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         irq_ff  <= |(nxt_stat & mask_ff);
      end
   end

   // Read mux; port reads show pin levels, shared bytes show live input data
   always_comb begin
      nxt_rdata = 8'h00;
      if (seg_hit) begin
         nxt_rdata = seg_rd[seg_idx];
      end else if (map_hit) begin
         nxt_rdata = map_ff[8*map_idx +: 8];
      end else if (rsel_hit) begin
         nxt_rdata = rsel_ff[rsel_idx];
      end else if (ded_hit && (ded_idx != 2'h3)) begin
         nxt_rdata = ded_rd[ded_idx];
      end else begin
         case (addr)
            `SDLPC_A_PORT0: nxt_rdata = general_pin_in[7:0];
            `SDLPC_A_PORT1: nxt_rdata = general_pin_in[15:8];
            `SDLPC_A_PORT2: nxt_rdata = general_pin_in[23:16];
            `SDLPC_A_PORT3: nxt_rdata = general_pin_in[31:24];
            `SDLPC_A_PORT4: nxt_rdata = {4'h0, general_pin_in[35:32]};
            `SDLPC_A_DIR0:  nxt_rdata = dir_ff[7:0];
            `SDLPC_A_DIR1:  nxt_rdata = dir_ff[15:8];
            `SDLPC_A_DIR2:  nxt_rdata = dir_ff[23:16];
            `SDLPC_A_STAT:  nxt_rdata = {6'h00, stat_ff};
            `SDLPC_A_MASK:  nxt_rdata = {6'h00, mask_ff};
            `SDLPC_A_CTRL:  nxt_rdata = ctrl_ff;
            default:        nxt_rdata = 8'h00;
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= rd_stb ? nxt_rdata : 8'h00;
      end
   end

   assign rdata                 = rdata_ff;
   assign general_pin_out       = pin_out_ff;
   assign general_pin_oe        = pin_oe_ff;
   assign pin_lcd_select        = lcd_ff;
   assign uart_rx_data          = rx_ff;
   assign ee_data_in            = ee_in_ff;
   assign counter_zero_clock    = t0_ff;
   assign counter_one_clock     = t1_ff;
   assign high_priority_pin_irq = hi_ff;
   assign low_priority_pin_irq  = lo_ff;
   assign irq                   = irq_ff;

   // Checks on pin resolution and routing
   AST_DIR_SEG: assert property (@(posedge mclk) disable iff (rst)
      !$past(rst) |-> general_pin_oe[43] == $past(!map_ff[19] && seg_ff[9][7]))
      else $error("pin 43 direction not from segment bit 3");
   AST_DATA_SEG: assert property (@(posedge mclk) disable iff (rst)
      !$past(rst) |-> general_pin_out[43] == $past(seg_ff[9][4]))
      else $error("pin 43 data not from segment field bit 0");
   AST_DED_PIN: assert property (@(posedge mclk) disable iff (rst)
      !$past(rst) |-> general_pin_oe[57] == $past(ded_ff[1][7])
         && general_pin_out[57] == $past(ded_ff[1][4]))
      else $error("pin 57 not from its dedicated byte");
   AST_EE_PINS: assert property (@(posedge mclk) disable iff (rst)
      $past(ctrl_ff[1]) && !$past(rst) |-> general_pin_oe[4]
         && general_pin_out[4] == $past(ee_clk))
      else $error("EEPROM clock not on pin 4");
   AST_PULSE_W: assert property (@(posedge mclk) disable iff (rst)
      $past(ctrl_ff[2] && dir_ff[6]) && !$past(rst)
         |-> general_pin_out[6] == $past(real_energy_pulse))
      else $error("real energy pulse not on pin 6");
   AST_PULSE_Y: assert property (@(posedge mclk) disable iff (rst)
      $past(ctrl_ff[5] && dir_ff[9]) && !$past(rst)
         |-> general_pin_out[9] == $past(extra_pulse_y))
      else $error("extra pulse Y not on pin 9");
   AST_OPTICAL_TRANSMIT_PIN: assert property (@(posedge mclk) disable iff (rst)
      !$past(ctrl_ff[0]) && !$past(rst) |-> general_pin_oe[1] && !general_pin_oe[2]
         && general_pin_out[1] == $past(uart_tx_data))
      else $error("optical transmit not on pin 1");
   AST_BTN_RISE: assert property (@(posedge mclk) disable iff (rst)
      push_button_input && !src_prev_ff[0] && rsel_ff[0][2:0] == 3'h4
         |=> high_priority_pin_irq && stat_ff[0])
      else $error("button rise did not reach high priority irq");
   AST_LCD_NODRV: assert property (@(posedge mclk) disable iff (rst)
      $past(map_ff[19]) && !$past(rst) |-> !general_pin_oe[43] && pin_lcd_select[43])
      else $error("pin 43 driven while in segment use");
   AST_OR_T0: assert property (@(posedge mclk) disable iff (rst)
      src_lvl[1] && rsel_ff[0][6:4] == 3'h2 |=> counter_zero_clock)
      else $error("counter 0 clock misses a selected source");
endmodule

// >>> test/sdlpc_testbench.sv
// Self-checking bench for the shared pin control block: bus, pins, routing, interrupts.
// Assumes the design sources and sdlpc_params.svh are compiled alongside this file.
`timescale 1ns/1ps
`include "sdlpc_params.svh"

module testbench;
   import sdlpc_pkg::*;
   logic        mclk, rst, wr_stb, rd_stb, pb, utx, pw, pv, px, py, eck, edo, edoe;
   sdlpc_addr_t addr;
   sdlpc_byte_t wdata, rdata, rb;
   logic [58:0] ext, pin_lvl, pin_out, pin_oe, lcd_sel;
   logic        urx, edi, t0c, t1c, hirq, lirq, irq;
   logic [7:0]  dir, dat;
   int          failures, checks;

   // Pad model: a driven pin reads back its own value, so output pulses can be tracked
   assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext);

   sdlpc_top i_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .general_pin_in(pin_lvl), .general_pin_out(pin_out),
      .general_pin_oe(pin_oe), .pin_lcd_select(lcd_sel), .push_button_input(pb),
      .uart_tx_data(utx), .uart_rx_data(urx), .real_energy_pulse(pw),
      .reactive_energy_pulse(pv), .extra_pulse_x(px), .extra_pulse_y(py), .ee_clk(eck),
      .ee_data_out(edo), .ee_data_oe(edoe), .ee_data_in(edi), .counter_zero_clock(t0c),
      .counter_one_clock(t1c), .high_priority_pin_irq(hirq), .low_priority_pin_irq(lirq),
      .irq(irq));

   task automatic end_sim();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Waits n edges, then lets that edge's updates settle
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // Strobe rises after one edge and falls after the edge that takes it
   task automatic wr(input sdlpc_addr_t a, input sdlpc_byte_t d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'h1;
      @(posedge mclk);
      wr_stb <= 1'h0;
   endtask

   task automatic rd(input sdlpc_addr_t a, output sdlpc_byte_t d);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'h1;
      @(posedge mclk);
      rd_stb <= 1'h0;
      #1;
      d = rdata;
   endtask

   // Expected {t0, t1, high irq, low irq} one cycle after the source steps to lvl
   function automatic logic [3:0] route_exp(input logic [2:0] c, input logic lvl);
      route_exp = {lvl && c == 3'h2, lvl && c == 3'h3, (lvl && c == 3'h4) || (!lvl && c == 3'h6),
                   (lvl && c == 3'h5) || (!lvl && c == 3'h7)};
   endfunction

   // Clock
   initial begin
      mclk = 1'h0;
      forever #2 mclk = ~mclk;
   end

   // Watchdog sized well above the expected run of a few hundred cycles
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      end_sim();
   end

   // Main sequence
   initial begin
      rst = 1'h1;
      {addr, wdata, ext, wr_stb, rd_stb, pb, utx, pw, pv, px, py, eck, edo, edoe} = '0;
      void'($urandom(32'h6D62));
      repeat (3) @(posedge mclk);
      rst <= 1'h0;
      utx <= 1'h1;
      ext <= 59'({$urandom(), $urandom()});
      cyc(3);
      chk("oe after reset", 64'h2, 64'(pin_oe));
      chk("tx pin", 64'h1, 64'(pin_out[1]));
      chk("rx copy", 64'(ext[2]), 64'(urx));
      wr(`SDLPC_A_CTRL, 8'h01);
      repeat (4) begin
         dir = 8'($urandom());
         dat = 8'($urandom());
         @(posedge mclk);
         ext <= 59'({$urandom(), $urandom()});
         wr(`SDLPC_A_DIR0, dir);
         wr(`SDLPC_A_PORT0, dat);
         cyc(2);
         chk("port0 oe", 64'(dir), 64'(pin_oe[7:0]));
         chk("port0 out", 64'(dat & dir), 64'(pin_out[7:0] & dir));
         rd(`SDLPC_A_PORT0, rb);
         chk("port0 read", 64'((dat & dir) | (ext[7:0] & ~dir)), 64'(rb));
      end
      wr(`SDLPC_A_CTRL, 8'h3D);
      wr(`SDLPC_A_DIR0, 8'hC0);
      wr(`SDLPC_A_DIR1, 8'h03);
      repeat (4) begin
         @(posedge mclk);
         {pw, pv, px, py} <= 4'($urandom());
         cyc(2);
         chk("pulse pins", 64'({py, px, pv, pw}), 64'(pin_out[9:6]));
      end
      wr(`SDLPC_A_CTRL, 8'h03);
      repeat (4) begin
         @(posedge mclk);
         {eck, edo, edoe} <= 3'($urandom());
         cyc(2);
         chk("ee pins", 64'({edoe, 1'h1, edo & edoe, eck}),
             64'({pin_oe[5:4], pin_out[5] & pin_oe[5], pin_out[4]}));
         chk("ee in", 64'(edoe ? edo : ext[5]), 64'(edi));
      end
      // Pin 43 lives in the upper nibble of a shared segment byte
      wr(16'h2045, 8'h90);
      cyc(2);
      chk("pin43 drive", 64'h3, 64'({pin_oe[43], pin_out[43]}));
      // Pin 42 shares the byte; as an I/O input its data bit reads the live level
      rd(16'h2045, rb);
      chk("pin43 byte", 64'({4'h9, 3'h0, ext[42]}), 64'(rb));
      wr(16'h2045, (rb & 8'hF0) | 8'h05);
      cyc(2);
      chk("pin43 kept", 64'h3, 64'({pin_oe[43], pin_out[43]}));
      wr(16'h2045, 8'h85);
      cyc(2);
      chk("pin43 low", 64'h2, 64'({pin_oe[43], pin_out[43]}));
      wr(`SDLPC_A_MAP_LO + 16'h2, 8'h08);
      cyc(2);
      chk("pin43 segment", 64'h2, 64'({lcd_sel[43], pin_oe[43]}));
      for (int i = 0; i < 3; i++) begin
         dir = 8'($urandom());
         wr(16'(`SDLPC_A_DED_LO + i), dir & 8'h90);
         cyc(2);
         chk("dedicated pin", 64'({dir[7], dir[7] & dir[4]}),
             64'({pin_oe[56 + i], pin_out[56 + i] & pin_oe[56 + i]}));
      end
      rd(16'h2053, rb);
      chk("unmapped read", 64'h0, 64'(rb));
      wr(`SDLPC_A_MASK, 8'h03);
      for (int c = 0; c < 8; c++) begin
         wr(`SDLPC_A_RSEL_LO, 8'(c));
         for (int s = 1; s >= 0; s--) begin
            @(posedge mclk);
            pb <= s[0];
            cyc(1);
            chk("routed", 64'(route_exp(3'(c), s[0])), 64'({t0c, t1c, hirq, lirq}));
         end
         rd(`SDLPC_A_STAT, rb);
         chk("status", 64'({c == 5 || c == 7, c == 4 || c == 6}), 64'(rb));
         chk("irq", 64'(c >= 4), 64'(irq));
         wr(`SDLPC_A_STAT, 8'h03);
         cyc(2);
         chk("irq cleared", 64'h0, 64'(irq));
      end
      // Masked event still latches status but keeps the line low
      wr(`SDLPC_A_MASK, 8'h00);
      wr(`SDLPC_A_RSEL_LO, 8'h04);
      pb <= 1'h1;
      cyc(2);
      chk("masked irq", 64'h0, 64'(irq));
      rd(`SDLPC_A_STAT, rb);
      chk("masked status", 64'h1, 64'(rb));
      // Driven pin 0 and the button share counter 0 clock
      @(posedge mclk);
      pb <= 1'h0;
      ext <= '0;
      wr(`SDLPC_A_RSEL_LO, 8'h22);
      wr(`SDLPC_A_DIR0, 8'h01);
      wr(`SDLPC_A_PORT0, 8'h01);
      cyc(3);
      chk("t0 from output", 64'h1, 64'(t0c));
      @(posedge mclk);
      pb <= 1'h1;
      wr(`SDLPC_A_PORT0, 8'h00);
      cyc(3);
      chk("t0 or", 64'h1, 64'(t0c));
      @(posedge mclk);
      pb <= 1'h0;
      cyc(3);
      chk("t0 idle", 64'h0, 64'(t0c));
      end_sim();
   end
endmodule
